// ---- logic/timer_pkg.sv ----
// Constants, types and field layouts shared by the dual 12-bit counter block
package timer_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Port address space
    localparam int PORT_ADDR_WIDTH = 5;
    localparam logic [4:0] FIRST_COMMAND_ADDR = 5'h1C;
    localparam logic [4:0] SECOND_COMMAND_ADDR = 5'h1D;
    localparam logic [3:0] COMMAND_RESET = 4'h0;

    ////////////////////////////////////////////////////////////////////////
    // RAM nibble map of the count registers, low nibble first
    localparam int RAM_ADDR_WIDTH = 7;
    localparam logic [6:0] FIRST_COUNT_BASE = 7'h74;
    localparam logic [6:0] SECOND_COUNT_BASE = 7'h78;
    localparam logic [1:0] NIBBLE_LOW = 2'h0;
    localparam logic [1:0] NIBBLE_MID = 2'h1;
    localparam logic [1:0] NIBBLE_HIGH = 2'h2;

    ////////////////////////////////////////////////////////////////////////
    // Counter layout
    localparam int COUNT_WIDTH = 12;
    localparam logic [11:0] COUNT_RESET = 12'h000;
    localparam logic [11:0] COUNT_ALL_ONES = 12'hFFF;
    localparam logic [11:0] COUNT_STEP = 12'h001;

    // Command fields: bits 3..2 mode, bits 1..0 rate select
    localparam int MODE_MSB = 3;
    localparam int MODE_LSB = 2;
    localparam int RATE_MSB = 1;
    localparam int RATE_LSB = 0;

    typedef enum logic [1:0] {
        MODE_STOP = 2'b00,
        MODE_EVENT = 2'b01,
        MODE_TIMER = 2'b10,
        MODE_WIDTH = 2'b11
    } mode_type;

    ////////////////////////////////////////////////////////////////////////
    // Prescaler: 22 stages, rate taps give clock/2^10, 2^14, 2^18, 2^22
    localparam int PRESCALE_WIDTH = 22;
    localparam logic [21:0] PRESCALE_RESET = 22'h000000;
    localparam logic [21:0] PRESCALE_STEP = 22'h000001;
    localparam int RATE_TAP_0 = 9;
    localparam int RATE_TAP_1 = 13;
    localparam int RATE_TAP_2 = 17;
    localparam int RATE_TAP_3 = 21;

    ////////////////////////////////////////////////////////////////////////
    // Bus carriers
    typedef struct packed {
        logic write;
        logic [4:0] addr;
        logic [3:0] data;
    } port_write_type;

    typedef struct packed {
        logic read;
        logic write;
        logic [6:0] addr;
        logic [3:0] data;
    } ram_access_type;

endpackage

// ---- logic/count_channel.sv ----
// One 12-bit counter channel: command, request latch and count nibbles
`timescale 1ns/10ps
module count_channel #(
    parameter logic [6:0] ram_base = 7'h00
) (
    // Clock and control
    input wire logic clk,
    input wire logic reset,
    input wire logic clk_en,
    // Command port and RAM access
    input wire logic command_write,
    input wire logic [3:0] command_data,
    input wire timer_pkg::ram_access_type ram,
    // Count sources
    input wire logic pin_level,
    input wire logic pin_rise,
    input wire logic [3:0] rate_rise,
    // Arbitration
    input wire logic grant,
    output logic request,
    // Results
    output logic [11:0] count,
    output logic overflow,
    output logic uses_pin
);

    logic [3:0] command;
    logic pending;
    logic pulse_rise;
    logic rate_pick;
    timer_pkg::mode_type mode;

    ////////////////////////////////////////////////////////////////////////
    // Command register, cleared by reset
    always_ff @(posedge clk) begin
        if (reset) begin
            command <= timer_pkg::COMMAND_RESET;
        end else if (clk_en && command_write) begin
            command <= command_data;
        end
    end

    // Mode decode and selected count pulse
    always_comb begin
        mode = timer_pkg::mode_type'(
            command[timer_pkg::MODE_MSB:timer_pkg::MODE_LSB]);
        rate_pick = rate_rise[command[timer_pkg::RATE_MSB:timer_pkg::RATE_LSB]];
        case (mode)
            timer_pkg::MODE_STOP: pulse_rise = 1'b0;
            timer_pkg::MODE_EVENT: pulse_rise = pin_rise;
            timer_pkg::MODE_TIMER: pulse_rise = rate_pick;
            timer_pkg::MODE_WIDTH: pulse_rise = rate_pick & pin_level;
            default: pulse_rise = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Request latch; a write discards edges seen before it, a new edge
    // wins over the grant that would clear it
    always_ff @(posedge clk) begin
        if (reset) begin
            pending <= 1'b0;
        end else if (clk_en) begin
            if (command_write) begin
                pending <= 1'b0;
            end else if (pulse_rise) begin
                pending <= 1'b1;
            end else if (grant) begin
                pending <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Count nibbles; increment beats a RAM store, which cannot coincide
    // anyway because the inserted cycle holds the processor
    always_ff @(posedge clk) begin
        if (reset) begin
            count <= timer_pkg::COUNT_RESET;
        end else if (clk_en) begin
            if (grant) begin
                count <= count + timer_pkg::COUNT_STEP;
            end else if (ram.write && ram.addr == ram_base + 7'(timer_pkg::NIBBLE_LOW)) begin
                count[3:0] <= ram.data;
            end else if (ram.write && ram.addr == ram_base + 7'(timer_pkg::NIBBLE_MID)) begin
                count[7:4] <= ram.data;
            end else if (ram.write && ram.addr == ram_base + 7'(timer_pkg::NIBBLE_HIGH)) begin
                count[11:8] <= ram.data;
            end
        end
    end

    // Overflow pulse on the wrap to zero
    always_ff @(posedge clk) begin
        if (reset) begin
            overflow <= 1'b0;
        end else if (clk_en) begin
            overflow <= grant && count == timer_pkg::COUNT_ALL_ONES;
        end
    end

    assign request = pending;
    assign uses_pin = mode == timer_pkg::MODE_EVENT
        || mode == timer_pkg::MODE_WIDTH;

endmodule // count_channel

// ---- logic/dual_twelve_bit_timer_counter.sv ----
// Top of the dual 12-bit counter block with count-cycle arbitration
`timescale 1ns/10ps
module dual_twelve_bit_timer_counter (
    // Clock, reset, clock enable
    input wire logic CLK,
    input wire logic RESET,
    input wire logic CLK_EN,
    // Processor instruction timing
    input wire logic CYCLE_START,
    input wire logic INSTR_DONE,
    // Port write bus for the command registers
    input wire timer_pkg::port_write_type PORT,
    // RAM access bus for the count nibbles
    input wire timer_pkg::ram_access_type RAM,
    // Counter input pin
    input wire logic COUNT_INPUT_PIN,
    // Processor hold and service indication
    output logic INSERT_CYCLE,
    output logic FIRST_SERVICED,
    output logic SECOND_SERVICED,
    // RAM read answer
    output logic RAM_HIT,
    output logic [3:0] RAM_RDATA,
    // Overflow interrupt requests
    output logic FIRST_OVERFLOW,
    output logic SECOND_OVERFLOW,
    // Pin taken by a counter mode
    output logic PIN_IN_USE
);

    ////////////////////////////////////////////////////////////////////////
    // Declarations

    logic pin_meta;
    logic pin_mid;
    logic pin_late;
    logic pin_level;
    logic pin_agree;
    logic pin_rise;

    logic [21:0] prescale;
    logic [3:0] rate_level;
    logic [3:0] rate_prev;
    logic [3:0] rate_rise;

    logic first_write;
    logic second_write;

    logic first_request;
    logic second_request;
    logic first_grant;
    logic second_grant;
    logic decision;

    logic [11:0] first_count;
    logic [11:0] second_count;
    logic first_overflow;
    logic second_overflow;
    logic first_uses_pin;
    logic second_uses_pin;

    logic first_hit;
    logic second_hit;
    logic [3:0] next_rdata;

    ////////////////////////////////////////////////////////////////////////
    // Pin synchroniser: three stages, a change counts once the second
    // and third stage agree, which filters a single metastable sample
    always_ff @(posedge CLK) begin
        if (RESET) begin
            pin_meta <= 1'b0;
            pin_mid <= 1'b0;
            pin_late <= 1'b0;
        end else if (CLK_EN) begin
            pin_meta <= COUNT_INPUT_PIN;
            pin_mid <= pin_meta;
            pin_late <= pin_mid;
        end
    end

    // Agreement of the two settled stages
    assign pin_agree = pin_mid == pin_late;

    // Accepted pin level
    always_ff @(posedge CLK) begin
        if (RESET) begin
            pin_level <= 1'b0;
        end else if (CLK_EN && pin_agree) begin
            pin_level <= pin_late;
        end
    end

    // Rising edge of the accepted level; the source must stay at or
    // above a 32-clock period, so each edge is seen cleanly
    assign pin_rise = pin_agree && pin_late && !pin_level;

    ////////////////////////////////////////////////////////////////////////
    // Prescaler: free running from reset, never cleared by a command,
    // so the first timer count may come early after a write
    always_ff @(posedge CLK) begin
        if (RESET) begin
            prescale <= timer_pkg::PRESCALE_RESET;
        end else if (CLK_EN) begin
            prescale <= prescale + timer_pkg::PRESCALE_STEP;
        end
    end

    // Rate taps, slowest divide last
    always_comb begin
        rate_level[0] = prescale[timer_pkg::RATE_TAP_0];
        rate_level[1] = prescale[timer_pkg::RATE_TAP_1];
        rate_level[2] = prescale[timer_pkg::RATE_TAP_2];
        rate_level[3] = prescale[timer_pkg::RATE_TAP_3];
    end

    // Previous tap levels for rising-edge detection
    always_ff @(posedge CLK) begin
        if (RESET) begin
            rate_prev <= 4'h0;
        end else if (CLK_EN) begin
            rate_prev <= rate_level;
        end
    end

    // One-clock pulse on each tap rising edge
    assign rate_rise = rate_level & ~rate_prev;

    ////////////////////////////////////////////////////////////////////////
    // Command register decode
    assign first_write = PORT.write
        && PORT.addr == timer_pkg::FIRST_COMMAND_ADDR;
    assign second_write = PORT.write
        && PORT.addr == timer_pkg::SECOND_COMMAND_ADDR;

    ////////////////////////////////////////////////////////////////////////
    // Counter channels
    count_channel #(
        .ram_base(timer_pkg::FIRST_COUNT_BASE)
    ) first_counter (
        .clk(CLK),
        .reset(RESET),
        .clk_en(CLK_EN),
        .command_write(first_write),
        .command_data(PORT.data),
        .ram(RAM),
        .pin_level(pin_level),
        .pin_rise(pin_rise),
        .rate_rise(rate_rise),
        .grant(first_grant),
        .request(first_request),
        .count(first_count),
        .overflow(first_overflow),
        .uses_pin(first_uses_pin)
    );

    count_channel #(
        .ram_base(timer_pkg::SECOND_COUNT_BASE)
    ) second_counter (
        .clk(CLK),
        .reset(RESET),
        .clk_en(CLK_EN),
        .command_write(second_write),
        .command_data(PORT.data),
        .ram(RAM),
        .pin_level(pin_level),
        .pin_rise(pin_rise),
        .rate_rise(rate_rise),
        .grant(second_grant),
        .request(second_request),
        .count(second_count),
        .overflow(second_overflow),
        .uses_pin(second_uses_pin)
    );

    ////////////////////////////////////////////////////////////////////////
    // Arbitration. A count cycle may start only where an instruction has
    // just finished, or right after another inserted cycle, so a pending
    // second request follows the first back to back
    assign decision = CLK_EN && CYCLE_START
        && (INSTR_DONE || INSERT_CYCLE);

    // First counter has priority; the second waits one instruction cycle
    assign first_grant = decision && first_request;
    assign second_grant = decision && !first_request
        && second_request;

    // Hold output spans exactly one instruction cycle per count
    always_ff @(posedge CLK) begin
        if (RESET) begin
            INSERT_CYCLE <= 1'b0;
        end else if (CLK_EN && CYCLE_START) begin
            INSERT_CYCLE <= first_grant || second_grant;
        end
    end

    // Which counter owns the inserted cycle
    always_ff @(posedge CLK) begin
        if (RESET) begin
            FIRST_SERVICED <= 1'b0;
            SECOND_SERVICED <= 1'b0;
        end else if (CLK_EN && CYCLE_START) begin
            FIRST_SERVICED <= first_grant;
            SECOND_SERVICED <= second_grant;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Overflow requests, one clock each, to the interrupt latches
    always_ff @(posedge CLK) begin
        if (RESET) begin
            FIRST_OVERFLOW <= 1'b0;
            SECOND_OVERFLOW <= 1'b0;
        end else if (CLK_EN) begin
            FIRST_OVERFLOW <= first_overflow;
            SECOND_OVERFLOW <= second_overflow;
        end
    end

    // Pin ownership, used by the port logic to release the shared pin
    always_ff @(posedge CLK) begin
        if (RESET) begin
            PIN_IN_USE <= 1'b0;
        end else if (CLK_EN) begin
            PIN_IN_USE <= first_uses_pin || second_uses_pin;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // RAM read of the count nibbles
    assign first_hit = RAM.addr >= timer_pkg::FIRST_COUNT_BASE
        && RAM.addr <= timer_pkg::FIRST_COUNT_BASE
        + 7'(timer_pkg::NIBBLE_HIGH);
    assign second_hit = RAM.addr >= timer_pkg::SECOND_COUNT_BASE
        && RAM.addr <= timer_pkg::SECOND_COUNT_BASE
        + 7'(timer_pkg::NIBBLE_HIGH);

    // Nibble selection; the RAM shadows the live count
    always_comb begin
        next_rdata = 4'h0;
        if (first_hit) begin
            case (2'(RAM.addr - timer_pkg::FIRST_COUNT_BASE))
                timer_pkg::NIBBLE_LOW: next_rdata = first_count[3:0];
                timer_pkg::NIBBLE_MID: next_rdata = first_count[7:4];
                timer_pkg::NIBBLE_HIGH: next_rdata = first_count[11:8];
                default: next_rdata = 4'h0;
            endcase
        end else if (second_hit) begin
            case (2'(RAM.addr - timer_pkg::SECOND_COUNT_BASE))
                timer_pkg::NIBBLE_LOW: next_rdata = second_count[3:0];
                timer_pkg::NIBBLE_MID: next_rdata = second_count[7:4];
                timer_pkg::NIBBLE_HIGH: next_rdata = second_count[11:8];
                default: next_rdata = 4'h0;
            endcase
        end
    end

    // Registered read answer, one clock after the strobe
    always_ff @(posedge CLK) begin
        if (RESET) begin
            RAM_HIT <= 1'b0;
            RAM_RDATA <= 4'h0;
        end else if (CLK_EN) begin
            RAM_HIT <= RAM.read && (first_hit || second_hit);
            RAM_RDATA <= RAM.read ? next_rdata : 4'h0;
        end
    end

endmodule // dual_twelve_bit_timer_counter

// ---- bench/timer_chk.sv ----
// Port assertions for the dual 12-bit counter block
`timescale 1ns/10ps
module timer_chk (
    // Clock and reset
    input wire logic CLK,
    input wire logic RESET,
    input wire logic CLK_EN,
    // Inputs watched
    input wire logic CYCLE_START,
    input wire logic INSTR_DONE,
    input wire timer_pkg::port_write_type PORT,
    input wire timer_pkg::ram_access_type RAM,
    // Outputs watched
    input wire logic INSERT_CYCLE,
    input wire logic FIRST_SERVICED,
    input wire logic SECOND_SERVICED,
    input wire logic RAM_HIT,
    input wire logic FIRST_OVERFLOW,
    input wire logic SECOND_OVERFLOW,
    input wire logic PIN_IN_USE
);
    default clocking @(posedge CLK); endclocking
    default disable iff (RESET);
    logic map_hit;
    ////////////////////////////////////////////////////////////////////////
    // Nibble addresses that belong to the two count registers
    assign map_hit = RAM.addr inside {7'h74, 7'h75, 7'h76, 7'h78, 7'h79, 7'h7A};
    AST_INSERT_START: assert property (
        $rose(INSERT_CYCLE) |-> $past(CYCLE_START) && $past(INSTR_DONE))
        else $error("count cycle began off an instruction boundary");
    AST_INSERT_HOLD: assert property (
        INSERT_CYCLE && !CYCLE_START |=> INSERT_CYCLE)
        else $error("count cycle ended early");
    AST_SERVICE_ONE: assert property (
        INSERT_CYCLE == (FIRST_SERVICED ^ SECOND_SERVICED))
        else $error("service flags disagree with count cycle");
    AST_SECOND_NEXT: assert property (
        $fell(FIRST_SERVICED) && INSERT_CYCLE |-> SECOND_SERVICED)
        else $error("held cycle after first is not for second");
    AST_SERVICE_EDGE: assert property (
        $changed(FIRST_SERVICED) || $changed(SECOND_SERVICED)
        |-> $past(CYCLE_START))
        else $error("service flag moved inside an instruction cycle");
    AST_FIRST_WRAP: assert property (
        FIRST_OVERFLOW |-> $past(FIRST_SERVICED)
        && !$past(FIRST_SERVICED, 2) ##1 !FIRST_OVERFLOW)
        else $error("first wrap pulse misplaced");
    AST_SECOND_WRAP: assert property (
        SECOND_OVERFLOW |-> $past(SECOND_SERVICED)
        && !$past(SECOND_SERVICED, 2) ##1 !SECOND_OVERFLOW)
        else $error("second wrap pulse misplaced");
    AST_EVENT_PIN: assert property (
        CLK_EN && PORT.write && PORT.addr == timer_pkg::SECOND_COMMAND_ADDR
        && PORT.data[3:2] == timer_pkg::MODE_EVENT |-> ##2 PIN_IN_USE)
        else $error("event mode did not claim the pin");
    AST_RAM_ANSWER: assert property (
        CLK_EN && RAM.read |=> RAM_HIT == $past(map_hit))
        else $error("count nibble read answered wrongly");
endmodule // timer_chk

// ---- bench/pulse_source.sv ----
// External pulse source that drives the counter input pin
`timescale 1ns/10ps
module pulse_source (
    // Control from the bench
    input wire logic clk,
    input wire logic rst,
    input wire logic start,
    input wire logic [7:0] pulses,
    input wire logic idle_level,
    // Pin side
    output logic pin,
    output logic busy
);
    logic [7:0] left;
    logic [4:0] phase;
    // A 32-clock period is the fastest rate the pin may legally carry
    always_ff @(posedge clk) begin
        if (rst) begin
            busy <= 1'b0;
        end else if (start) begin
            left <= pulses;
            phase <= 5'h00;
            busy <= 1'b1;
        end else if (busy) begin
            phase <= phase + 5'h01;
            if (phase == 5'h1F) begin
                left <= left - 8'h01;
                busy <= (left != 8'h01);
            end
        end
    end
    // Low half then high half; idle level between bursts
    assign pin = busy ? phase[4] : idle_level;
endmodule // pulse_source

// ---- bench/testbench.sv ----
// Self-checking bench for the dual 12-bit counter block
`timescale 1ns/10ps
module testbench;
    logic CLK, RESET, CLK_EN, CYCLE_START, INSTR_DONE, COUNT_INPUT_PIN;
    timer_pkg::port_write_type PORT;
    timer_pkg::ram_access_type RAM;
    logic INSERT_CYCLE, FIRST_SERVICED, SECOND_SERVICED, RAM_HIT;
    logic FIRST_OVERFLOW, SECOND_OVERFLOW, PIN_IN_USE, p1, p2;
    logic [3:0] RAM_RDATA;
    logic src_start, src_level, src_busy;
    logic [7:0] src_count;
    logic [2:0] phase;
    int cyc, fails, cmp_count, svc1, svc2, ovf2, last1, last2, gap1, gap2;

    initial begin
        CLK = 1'b0;
        forever #20 CLK = ~CLK;
    end

    dual_twelve_bit_timer_counter dut_u (.CLK(CLK), .RESET(RESET),
        .CLK_EN(CLK_EN), .CYCLE_START(CYCLE_START), .INSTR_DONE(INSTR_DONE),
        .PORT(PORT), .RAM(RAM), .COUNT_INPUT_PIN(COUNT_INPUT_PIN),
        .INSERT_CYCLE(INSERT_CYCLE), .FIRST_SERVICED(FIRST_SERVICED),
        .SECOND_SERVICED(SECOND_SERVICED), .RAM_HIT(RAM_HIT),
        .RAM_RDATA(RAM_RDATA), .FIRST_OVERFLOW(FIRST_OVERFLOW),
        .SECOND_OVERFLOW(SECOND_OVERFLOW), .PIN_IN_USE(PIN_IN_USE));
    pulse_source src_u (.clk(CLK), .rst(RESET), .start(src_start),
        .pulses(src_count), .idle_level(src_level), .pin(COUNT_INPUT_PIN),
        .busy(src_busy));

    ////////////////////////////////////////////////////////////////////////
    // Eight clocks per one-cycle instruction; track service starts and second-counter wraps
    always @(posedge CLK) begin
        phase <= phase + 3'h1;
        CYCLE_START <= (phase == 3'h7);
        cyc <= cyc + 1;
        p1 <= FIRST_SERVICED;
        p2 <= SECOND_SERVICED;
        if (FIRST_SERVICED && !p1) begin
            svc1 <= svc1 + 1;
            gap1 <= cyc - last1;
            last1 <= cyc;
        end
        if (SECOND_SERVICED && !p2) begin
            svc2 <= svc2 + 1;
            gap2 <= cyc - last2;
            last2 <= cyc;
        end
        if (SECOND_OVERFLOW) begin
            ovf2 <= ovf2 + 1;
        end
    end

    task automatic check(input logic [11:0] seen, input logic [11:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR %0t seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    // Command writes are one-clock strobes; settle before returning
    task automatic port_wr(input logic [4:0] a, input logic [3:0] d);
        @(posedge CLK);
        PORT <= '{1'b1, a, d};
        @(posedge CLK);
        PORT <= '0;
        #1;
    endtask
    task automatic ram_acc(input logic wr, input logic [6:0] a,
                           input logic [3:0] d);
        @(posedge CLK);
        RAM <= '{!wr, wr, a, d};
        @(posedge CLK);
        RAM <= '0;
        #1;
    endtask
    // Three nibbles, low first
    task automatic rd12(input logic [6:0] b, output logic [11:0] v);
        for (int i = 0; i < 3; i++) begin
            ram_acc(1'b0, b + 7'(i), 4'h0);
            check({11'h0, RAM_HIT}, 12'h001);
            v[4*i +: 4] = RAM_RDATA;
        end
    endtask
    task automatic wr12(input logic [6:0] b, input logic [11:0] v);
        for (int i = 0; i < 3; i++)
            ram_acc(1'b1, b + 7'(i), v[4*i +: 4]);
    endtask
    task automatic pulses(input logic [7:0] n);
        @(posedge CLK);
        src_count <= n;
        src_start <= 1'b1;
        @(posedge CLK);
        src_start <= 1'b0;
        @(posedge CLK);
        while (src_busy) @(posedge CLK);
        repeat (40) @(posedge CLK);
    endtask
    // Bounded by the run timeout below
    task automatic wait_first();
        int s;
        s = svc1;
        while (svc1 == s) @(posedge CLK);
    endtask
    task automatic end_of_test();
        $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge CLK);
        fails++;
        end_of_test();
    end

    ////////////////////////////////////////////////////////////////////////
    initial begin
        logic [11:0] v;
        int s;
        RESET = 1'b1;
        CLK_EN = 1'b1;
        INSTR_DONE = 1'b1;
        PORT = '0;
        RAM = '0;
        {src_start, src_level, src_count, phase, CYCLE_START, p1, p2} = '0;
        {cyc, fails, cmp_count, svc1, svc2, ovf2} = '0;
        {last1, last2, gap1, gap2} = '0;
        repeat (16) @(posedge CLK);
        RESET <= 1'b0;
        // Reset state; stopped counters leave stored nibbles alone
        check({11'h0, INSERT_CYCLE | PIN_IN_USE}, 12'h000);
        rd12(7'h74, v);
        check(v, 12'h000);
        wr12(7'h78, 12'h3A5);
        port_wr(5'h1E, 4'h8);
        repeat (2100) @(posedge CLK);
        rd12(7'h78, v);
        check(v, 12'h3A5);
        check(12'(svc1 + svc2), 12'h000);
        $display("Test stopped done");
        // Event counting across the wrap at the fastest pin rate
        wr12(7'h78, 12'hFFE);
        s = ovf2;
        port_wr(5'h1D, 4'h4);
        // Mode decode is registered once more on its way to the pin flag
        @(posedge CLK);
        #1;
        check({11'h0, PIN_IN_USE}, 12'h001);
        pulses(8'h03);
        port_wr(5'h1D, 4'h0);
        rd12(7'h78, v);
        check(v, 12'h001);
        check(12'(ovf2 - s), 12'h001);
        check(12'(gap2), 12'h020);
        $display("Test event done");
        // Both on the fastest internal rate, so requests collide
        wr12(7'h74, 12'hFFE);
        port_wr(5'h1C, 4'h8);
        port_wr(5'h1D, 4'h8);
        wait_first();
        wait_first();
        wait_first();
        check(12'(gap1), 12'h400);
        repeat (8) @(posedge CLK);
        #1;
        check({10'h0, FIRST_SERVICED, SECOND_SERVICED}, 12'h001);
        repeat (16) @(posedge CLK);
        port_wr(5'h1C, 4'h0);
        port_wr(5'h1D, 4'h0);
        rd12(7'h74, v);
        check(v, 12'h001);
        rd12(7'h78, v);
        check(v, 12'h004);
        $display("Test timer done");
        // Width mode: no counts while the pin is low, counts while high
        wr12(7'h74, 12'h000);
        port_wr(5'h1C, 4'hC);
        repeat (2100) @(posedge CLK);
        rd12(7'h74, v);
        check(v, 12'h000);
        src_level <= 1'b1;
        wait_first();
        wait_first();
        port_wr(5'h1C, 4'h0);
        src_level <= 1'b0;
        rd12(7'h74, v);
        check(v, 12'h002);
        $display("Test width done");
        end_of_test();
    end
endmodule // testbench

bind dual_twelve_bit_timer_counter timer_chk chk_u (.CLK(CLK),
    .RESET(RESET), .CLK_EN(CLK_EN), .CYCLE_START(CYCLE_START),
    .INSTR_DONE(INSTR_DONE), .PORT(PORT), .RAM(RAM),
    .INSERT_CYCLE(INSERT_CYCLE), .FIRST_SERVICED(FIRST_SERVICED),
    .SECOND_SERVICED(SECOND_SERVICED), .RAM_HIT(RAM_HIT),
    .FIRST_OVERFLOW(FIRST_OVERFLOW), .SECOND_OVERFLOW(SECOND_OVERFLOW),
    .PIN_IN_USE(PIN_IN_USE));
